// file: src/csq_pkg.sv
// shared constants and types of the bus cycle sequencer
package csq_pkg;

    // ************************************************************
    // widths and address steps
    // ************************************************************
    localparam int ADDR_W = 32;
    localparam int CNT_W = 16;
    localparam logic [31:0] PREF_OFS = 32'h0000_0002;
    localparam logic [31:0] VEC_LO_OFS = 32'h0000_0002;
    localparam logic [31:0] PUSH_L_OFS = 32'h0000_0002;
    localparam logic [31:0] PUSH_H_OFS = 32'h0000_0004;
    localparam logic [31:0] PUSH_X_OFS = 32'h0000_0006;
    localparam logic [31:0] REG_STEP = 32'h0000_0004;
    localparam logic [31:0] MOVE_STEP = 32'h0000_0001;
    localparam logic [7:0] LOCK_SET_BIT = 8'h80;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_ZERO = 16'h0000;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [31:0] ADDR_RST = 32'h0000_0000;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [1:0] IDX_RST = 2'h0;

    // ************************************************************
    // commands and states
    // ************************************************************
    typedef enum logic [2:0] {
        CMD_RESET = 3'h0,
        CMD_INTR = 3'h1,
        CMD_TRAP = 3'h2,
        CMD_RET = 3'h3,
        CMD_TSET = 3'h4,
        CMD_MOVE = 3'h5,
        CMD_MULTI = 3'h6
    } csq_cmd_e;

    typedef enum logic [15:0] {
        ST_IDLE = 16'h0001,
        ST_PREF = 16'h0002,
        ST_INT1 = 16'h0004,
        ST_PUSHL = 16'h0008,
        ST_PUSHH = 16'h0010,
        ST_PUSHX = 16'h0020,
        ST_VECH = 16'h0040,
        ST_VECL = 16'h0080,
        ST_INT2 = 16'h0100,
        ST_FETCH = 16'h0200,
        ST_MVRD = 16'h0400,
        ST_MVWR = 16'h0800,
        ST_MSH = 16'h1000,
        ST_MSL = 16'h2000,
        ST_TASR = 16'h4000,
        ST_TASW = 16'h8000
    } csq_state_e;

endpackage : csq_pkg

// file: src/csq_count.sv
// loadable down counter for transfers and registers
`timescale 1ns/1ps
`default_nettype none
module csq_count (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic load,
    input wire logic [15:0] loadVal,
    input wire logic dec,
    output logic [15:0] count,
    output logic last
);
    typedef struct packed {
        logic [15:0] cnt;
    } csq_cnt_s;

    csq_cnt_s q, d;

    always_comb begin
        d = q;
        if (load) begin
            d.cnt = loadVal;
        end else if (dec && q.cnt != csq_pkg::CNT_ZERO) begin
            d.cnt = q.cnt - csq_pkg::CNT_ONE;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '{cnt: csq_pkg::CNT_ZERO};
        end else if (clkEn) begin
            q <= d;
        end
    end

    assign count = q.cnt;
    assign last = (q.cnt == csq_pkg::CNT_ONE);
endmodule : csq_count
`default_nettype wire

// file: src/csq_bus_port.sv
// holds one bus request until the memory acknowledges it
`timescale 1ns/1ps
`default_nettype none
module csq_bus_port (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic issue,
    input wire logic [31:0] opAddr,
    input wire logic opWrite,
    input wire logic opByte,
    input wire logic opLock,
    input wire logic holdLock,
    input wire logic [15:0] opData,
    input wire logic busAck,
    output logic busReq,
    output logic [31:0] busAddr,
    output logic busWrite,
    output logic busByte,
    output logic busLock,
    output logic [15:0] busWdata,
    output logic busDone
);
    typedef struct packed {
        logic req;
        logic [31:0] addr;
        logic wr;
        logic byteAcc;
        logic lock;
        logic [15:0] data;
    } csq_port_s;

    csq_port_s q, d;

    always_comb begin
        d = q;
        if (issue) begin
            d.req = 1'b1;
            d.addr = opAddr;
            d.wr = opWrite;
            d.byteAcc = opByte;
            d.lock = opLock;
            d.data = opData;
        end else if (busDone) begin
            d.req = 1'b0;
            // lock stays up across a read-modify-write pair
            d.lock = q.lock & holdLock;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '{req: 1'b0, addr: csq_pkg::ADDR_RST, wr: 1'b0, byteAcc: 1'b0,
                   lock: 1'b0, data: csq_pkg::WORD_RST};
        end else if (clkEn) begin
            q <= d;
        end
    end

    assign busDone = q.req & busAck;
    assign busReq = q.req;
    assign busAddr = q.addr;
    assign busWrite = q.wr;
    assign busByte = q.byteAcc;
    assign busLock = q.lock;
    assign busWdata = q.data;
endmodule : csq_bus_port
`default_nettype wire

// file: src/csq_sequencer.sv
// bus cycle sequencer for instructions and exception handling
// Notes on behaviour
// RULE1: a block move reads from the address in gp_reg_five and writes to the address in gp_reg_six.
// RULE2: the source and destination addresses each advance by one after every moved byte.
// RULE3: the move count is the initial count_reg_byte or count_reg_word, and zero runs no transfer cycle.
// RULE4: a multi-register save or restore repeats the per-register stack pattern once per register.
// RULE5: a return ends with an instruction fetch at the start address being returned to.
// RULE6: software should use only gp_reg_zero, one, four or five as the test_and_set_insn pointer.
// RULE7: reset handling reads vector_address and vector_address plus two, one internal state, then fetches.
// RULE8: the trap or interrupt prefetch reads the stacked program counter plus two.
// RULE9: on wake from sleep or standby the prefetch becomes an internal state with no bus access.
// RULE10: interrupts run prefetch, internal, push low, high, extended_control_word, vectors, internal, fetch.
// RULE11: software_trap_insn stacks the same way and its last push is followed by a locked vector read.
// RULE12: test_and_set_insn does a locked byte read then a byte write to the same address.
`timescale 1ns/1ps
`default_nettype none
module csq_sequencer (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic cmdValid,
    input wire logic [2:0] cmdKind,
    output logic cmdReady,
    input wire logic wakeRecovery,
    input wire logic multiRestore,
    input wire logic countIsWord,
    input wire logic [31:0] gpRegFive,
    input wire logic [31:0] gpRegSix,
    input wire logic [15:0] countRegWord,
    input wire logic [2:0] regCount,
    input wire logic [31:0] stackPtr,
    input wire logic [31:0] progCounter,
    input wire logic [7:0] extendedControlWord,
    input wire logic [31:0] vectorAddress,
    input wire logic [31:0] returnAddr,
    input wire logic [31:0] effAddr,
    input wire logic [31:0] saveWord,
    output logic [1:0] regIdx,
    output logic [31:0] restoreWord,
    output logic [31:0] srcAddr,
    output logic [31:0] dstAddr,
    output logic [31:0] stackOut,
    output logic [31:0] fetchAddr,
    output logic intOp,
    output logic seqDone,
    output logic busReq,
    output logic [31:0] busAddr,
    output logic busWrite,
    output logic busByte,
    output logic busLock,
    output logic [15:0] busWdata,
    input wire logic busAck,
    input wire logic [15:0] busRdata
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        csq_pkg::csq_state_e st;
        logic issued;
        logic wake;
        logic restore;
        logic [31:0] pc;
        logic [31:0] src;
        logic [31:0] dst;
        logic [31:0] sp;
        logic [31:0] vec;
        logic [31:0] target;
        logic [31:0] rword;
        logic [7:0] ctlw;
        logic [7:0] moveByte;
        logic [1:0] idx;
        logic intOp;
        logic done;
    } csq_seq_s;

    csq_seq_s q, d;
    logic issue, isBus, busDone, cntLoad, cntDec, cntLast, opWr, opByte, opLock;
    logic [31:0] opAddr;
    logic [15:0] opData, cntInit, cntVal;
    csq_pkg::csq_state_e after;

    function automatic logic [15:0] moveCount(input logic isWord, input logic [15:0] raw);
        moveCount = isWord ? raw : {8'h00, raw[7:0]};
    endfunction : moveCount

    csq_count u_count (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .load(cntLoad),
        .loadVal(cntInit),
        .dec(cntDec),
        .count(cntVal),
        .last(cntLast)
    );

    csq_bus_port u_port (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .issue(issue),
        .opAddr(opAddr),
        .opWrite(opWr),
        .opByte(opByte),
        .opLock(opLock),
        .holdLock(q.st == csq_pkg::ST_TASR),
        .opData(opData),
        .busAck(busAck),
        .busReq(busReq),
        .busAddr(busAddr),
        .busWrite(busWrite),
        .busByte(busByte),
        .busLock(busLock),
        .busWdata(busWdata),
        .busDone(busDone)
    );

    // ************************************************************
    // cycle of each state
    // ************************************************************
    always_comb begin
        isBus = 1'b1;
        opAddr = q.pc;
        opWr = 1'b0;
        opByte = 1'b0;
        opLock = 1'b0;
        opData = csq_pkg::WORD_RST;
        after = csq_pkg::ST_IDLE;
        case (q.st)
            csq_pkg::ST_PREF: begin
                // RULE8 stacked pc plus two
                opAddr = q.pc + csq_pkg::PREF_OFS;
                // RULE9 wake turns read internal
                isBus = ~q.wake;
                after = csq_pkg::ST_INT1;
            end
            csq_pkg::ST_INT1: begin
                isBus = 1'b0;
                after = csq_pkg::ST_PUSHL;
            end
            // RULE10 push order
            csq_pkg::ST_PUSHL: begin
                opAddr = q.sp - csq_pkg::PUSH_L_OFS;
                opWr = 1'b1;
                opData = q.pc[15:0];
                after = csq_pkg::ST_PUSHH;
            end
            csq_pkg::ST_PUSHH: begin
                opAddr = q.sp - csq_pkg::PUSH_H_OFS;
                opWr = 1'b1;
                opData = q.pc[31:16];
                after = csq_pkg::ST_PUSHX;
            end
            // RULE11 control word pushed last
            csq_pkg::ST_PUSHX: begin
                opAddr = q.sp - csq_pkg::PUSH_X_OFS;
                opWr = 1'b1;
                opData = {8'h00, q.ctlw};
                after = csq_pkg::ST_VECH;
            end
            // RULE7 locked vector then plus two
            csq_pkg::ST_VECH: begin
                opAddr = q.vec;
                opLock = 1'b1;
                after = csq_pkg::ST_VECL;
            end
            csq_pkg::ST_VECL: begin
                opAddr = q.vec + csq_pkg::VEC_LO_OFS;
                after = csq_pkg::ST_INT2;
            end
            csq_pkg::ST_INT2: begin
                isBus = 1'b0;
                after = csq_pkg::ST_FETCH;
            end
            // RULE5 fetch at target
            csq_pkg::ST_FETCH: begin
                opAddr = q.target;
            end
            // RULE1 source and destination
            csq_pkg::ST_MVRD: begin
                opAddr = q.src;
                opByte = 1'b1;
                after = csq_pkg::ST_MVWR;
            end
            csq_pkg::ST_MVWR: begin
                opAddr = q.dst;
                opByte = 1'b1;
                opWr = 1'b1;
                opData = {8'h00, q.moveByte};
                after = cntLast ? csq_pkg::ST_IDLE : csq_pkg::ST_MVRD;
            end
            // RULE4 per-register pattern
            csq_pkg::ST_MSH: begin
                opAddr = q.restore ? q.sp : q.sp - csq_pkg::PUSH_H_OFS;
                opWr = ~q.restore;
                opData = saveWord[31:16];
                after = csq_pkg::ST_MSL;
            end
            csq_pkg::ST_MSL: begin
                opAddr = q.restore ? q.sp + csq_pkg::PUSH_L_OFS : q.sp - csq_pkg::PUSH_L_OFS;
                opWr = ~q.restore;
                opData = saveWord[15:0];
                after = cntLast ? csq_pkg::ST_IDLE : csq_pkg::ST_MSH;
            end
            // RULE12 locked read then write
            csq_pkg::ST_TASR: begin
                opAddr = q.src;
                opByte = 1'b1;
                opLock = 1'b1;
                after = csq_pkg::ST_TASW;
            end
            csq_pkg::ST_TASW: begin
                opAddr = q.src;
                opByte = 1'b1;
                opWr = 1'b1;
                opLock = 1'b1;
                opData = {8'h00, q.moveByte | csq_pkg::LOCK_SET_BIT};
            end
            default: begin
                isBus = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // sequencing
    // ************************************************************
    always_comb begin
        d = q;
        d.intOp = 1'b0;
        d.done = 1'b0;
        issue = 1'b0;
        cntLoad = 1'b0;
        cntDec = 1'b0;
        cntInit = csq_pkg::CNT_ZERO;
        if (q.st == csq_pkg::ST_IDLE) begin
            if (cmdValid) begin
                d.pc = progCounter;
                d.sp = stackPtr;
                d.vec = vectorAddress;
                d.ctlw = extendedControlWord;
                d.wake = wakeRecovery;
                d.restore = multiRestore;
                d.idx = csq_pkg::IDX_RST;
                case (cmdKind)
                    csq_pkg::CMD_RESET: d.st = csq_pkg::ST_VECH;
                    csq_pkg::CMD_INTR, csq_pkg::CMD_TRAP: d.st = csq_pkg::ST_PREF;
                    csq_pkg::CMD_RET: begin
                        d.target = returnAddr;
                        d.st = csq_pkg::ST_FETCH;
                    end
                    csq_pkg::CMD_TSET: begin
                        d.src = effAddr;
                        d.st = csq_pkg::ST_TASR;
                    end
                    csq_pkg::CMD_MOVE: begin
                        // RULE1 take both pointers
                        d.src = gpRegFive;
                        d.dst = gpRegSix;
                        cntInit = moveCount(countIsWord, countRegWord);
                        cntLoad = 1'b1;
                        // RULE3 zero count skips transfers
                        if (cntInit == csq_pkg::CNT_ZERO) begin
                            d.done = 1'b1;
                        end else begin
                            d.st = csq_pkg::ST_MVRD;
                        end
                    end
                    csq_pkg::CMD_MULTI: begin
                        cntInit = {13'h0000, regCount};
                        cntLoad = 1'b1;
                        d.st = csq_pkg::ST_MSH;
                    end
                    default: d.done = 1'b1;
                endcase
            end
        end else if (!isBus) begin
            d.intOp = 1'b1;
            d.st = after;
        end else if (!q.issued) begin
            issue = 1'b1;
            d.issued = 1'b1;
        end else if (busDone) begin
            d.issued = 1'b0;
            d.st = after;
            d.done = (after == csq_pkg::ST_IDLE);
            case (q.st)
                csq_pkg::ST_VECH: d.target[31:16] = busRdata;
                csq_pkg::ST_VECL: d.target[15:0] = busRdata;
                csq_pkg::ST_MVRD, csq_pkg::ST_TASR: d.moveByte = busRdata[7:0];
                csq_pkg::ST_MSH: d.rword[31:16] = busRdata;
                csq_pkg::ST_MVWR: begin
                    // RULE2 advance both pointers
                    d.src = q.src + csq_pkg::MOVE_STEP;
                    d.dst = q.dst + csq_pkg::MOVE_STEP;
                    cntDec = 1'b1;
                end
                csq_pkg::ST_MSL: begin
                    d.rword[15:0] = busRdata;
                    d.sp = q.restore ? q.sp + csq_pkg::REG_STEP : q.sp - csq_pkg::REG_STEP;
                    d.idx = q.idx + 2'h1;
                    cntDec = 1'b1;
                end
                default: d.issued = 1'b0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '{st: csq_pkg::ST_IDLE, issued: 1'b0, wake: 1'b0, restore: 1'b0,
                   pc: csq_pkg::ADDR_RST, src: csq_pkg::ADDR_RST, dst: csq_pkg::ADDR_RST,
                   sp: csq_pkg::ADDR_RST, vec: csq_pkg::ADDR_RST, target: csq_pkg::ADDR_RST,
                   rword: csq_pkg::ADDR_RST, ctlw: 8'h00, moveByte: 8'h00,
                   idx: csq_pkg::IDX_RST, intOp: 1'b0, done: 1'b0};
        end else if (clkEn) begin
            q <= d;
        end
    end

    assign cmdReady = (q.st == csq_pkg::ST_IDLE);
    assign regIdx = q.idx;
    assign restoreWord = q.rword;
    assign srcAddr = q.src;
    assign dstAddr = q.dst;
    assign stackOut = q.sp;
    assign fetchAddr = q.target;
    assign intOp = q.intOp;
    assign seqDone = q.done;

    // ************************************************************
    // checks
    // ************************************************************
    property p_move_regs; // RULE1
        @(posedge sys_clk) disable iff (sys_rst)
        (clkEn && cmdReady && cmdValid && cmdKind == csq_pkg::CMD_MOVE)
        |=> (srcAddr == $past(gpRegFive) && dstAddr == $past(gpRegSix));
    endproperty
    a_move_regs: assert property (p_move_regs) else $error("move pointers not taken"); // RULE1

    property p_move_step; // RULE2
        @(posedge sys_clk) disable iff (sys_rst)
        (clkEn && q.st == csq_pkg::ST_MVWR && busDone) |=> (srcAddr == $past(srcAddr) + 32'h1);
    endproperty
    a_move_step: assert property (p_move_step) else $error("source not advanced by one"); // RULE2

    property p_move_zero; // RULE3
        @(posedge sys_clk) disable iff (sys_rst)
        (clkEn && cmdReady && cmdValid && cmdKind == csq_pkg::CMD_MOVE && cntInit == 16'h0)
        |=> (cmdReady && seqDone && !busReq);
    endproperty
    a_move_zero: assert property (p_move_zero) else $error("zero count moved data"); // RULE3

    property p_multi_count; // RULE4
        @(posedge sys_clk) disable iff (sys_rst)
        (clkEn && q.st == csq_pkg::ST_MSL && busDone) |=> (cmdReady == $past(cntLast));
    endproperty
    a_multi_count: assert property (p_multi_count) else $error("register repeat count wrong"); // RULE4

    property p_fetch_addr; // RULE5
        @(posedge sys_clk) disable iff (sys_rst)
        (q.st == csq_pkg::ST_FETCH && busReq) |-> (busAddr == fetchAddr && !busWrite);
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("final fetch at wrong address"); // RULE5

    property p_reset_tail; // RULE7
        @(posedge sys_clk) disable iff (sys_rst || !clkEn)
        (q.st == csq_pkg::ST_VECL && busDone) |=> ##1 (intOp && q.st == csq_pkg::ST_FETCH);
    endproperty
    a_reset_tail: assert property (p_reset_tail) else $error("vector not followed by one internal state"); // RULE7

    property p_pref_addr; // RULE8
        @(posedge sys_clk) disable iff (sys_rst)
        (q.st == csq_pkg::ST_PREF && busReq) |-> (busAddr == q.pc + 32'h2);
    endproperty
    a_pref_addr: assert property (p_pref_addr) else $error("prefetch not at pc plus two"); // RULE8

    property p_wake_nobus; // RULE9
        @(posedge sys_clk) disable iff (sys_rst)
        (clkEn && q.st == csq_pkg::ST_PREF && q.wake) |=> (!busReq && intOp);
    endproperty
    a_wake_nobus: assert property (p_wake_nobus) else $error("bus used on wake prefetch"); // RULE9

    property p_exr_lockvec; // RULE11
        @(posedge sys_clk) disable iff (sys_rst || !clkEn)
        (q.st == csq_pkg::ST_PUSHX && busDone) |=> ##1 (busReq && busLock && busAddr == q.vec);
    endproperty
    a_exr_lockvec: assert property (p_exr_lockvec) else $error("locked vector read not next"); // RULE11

    property p_tas_lock; // RULE12
        @(posedge sys_clk) disable iff (sys_rst)
        (clkEn && q.st == csq_pkg::ST_TASR && busDone) |=> (busLock && q.st == csq_pkg::ST_TASW);
    endproperty
    a_tas_lock: assert property (p_tas_lock) else $error("lock dropped inside test and set"); // RULE12
endmodule : csq_sequencer
`default_nettype wire

// file: testbench/csq_mem_model.sv
// program and data memory answering the sequencer bus
`timescale 1ns/1ps
`default_nettype none
module csq_mem_model (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic slowMode,
    input wire logic busReq,
    input wire logic [31:0] busAddr,
    input wire logic busWrite,
    input wire logic busByte,
    input wire logic busLock,
    input wire logic [15:0] busWdata,
    output logic busAck,
    output logic [15:0] busRdata
);
    logic [1:0] waitCnt;
    logic [31:0] logA[$];
    logic [2:0] logK[$];
    logic [15:0] logD[$];
    // read data is the address scrambled; off the ack it toggles every cycle
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busAck <= 1'b0;
            waitCnt <= 2'h0;
            busRdata <= 16'h0000;
        end else if (busReq && busAck) begin
            busAck <= 1'b0;
            waitCnt <= 2'h0;
            busRdata <= ~busRdata;
            logA.push_back(busAddr);
            logK.push_back({busWrite, busLock, busByte});
            logD.push_back(busWdata);
        end else if (busReq && (!slowMode || waitCnt == 2'h3)) begin
            busAck <= 1'b1;
            busRdata <= busAddr[15:0] ^ 16'h5a5a;
        end else begin
            waitCnt <= busReq ? waitCnt + 2'h1 : 2'h0;
            busRdata <= ~busRdata;
        end
    end
endmodule : csq_mem_model
`default_nettype wire

// file: testbench/test_csq_sequencer.sv
// self-checking bench of the bus cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module test_csq_sequencer;
    logic sys_clk, sys_rst, cmdValid, cmdReady, wakeRecovery, multiRestore, countIsWord, slowMode;
    logic [2:0] cmdKind, regCount;
    logic [15:0] countRegWord, busWdata, busRdata;
    logic [31:0] gpRegFive, gpRegSix, stackPtr, progCounter, vectorAddress, returnAddr, effAddr, saveWord;
    logic [31:0] restoreWord, srcAddr, dstAddr, stackOut, fetchAddr, busAddr;
    logic [7:0] extendedControlWord;
    logic [1:0] regIdx;
    logic intOp, seqDone, busReq, busWrite, busByte, busLock, busAck;
    int error_cnt = 0;
    int compares = 0;
    int nInt = 0;
    csq_sequencer i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(1'b1), .cmdValid(cmdValid),
        .cmdKind(cmdKind), .cmdReady(cmdReady), .wakeRecovery(wakeRecovery), .multiRestore(multiRestore),
        .countIsWord(countIsWord), .gpRegFive(gpRegFive), .gpRegSix(gpRegSix), .countRegWord(countRegWord),
        .regCount(regCount), .stackPtr(stackPtr), .progCounter(progCounter),
        .extendedControlWord(extendedControlWord), .vectorAddress(vectorAddress), .returnAddr(returnAddr),
        .effAddr(effAddr), .saveWord(saveWord), .regIdx(regIdx), .restoreWord(restoreWord),
        .srcAddr(srcAddr), .dstAddr(dstAddr), .stackOut(stackOut), .fetchAddr(fetchAddr), .intOp(intOp),
        .seqDone(seqDone), .busReq(busReq), .busAddr(busAddr), .busWrite(busWrite), .busByte(busByte),
        .busLock(busLock), .busWdata(busWdata), .busAck(busAck), .busRdata(busRdata));
    csq_mem_model i_mem (.sys_clk(sys_clk), .sys_rst(sys_rst), .slowMode(slowMode), .busReq(busReq),
        .busAddr(busAddr), .busWrite(busWrite), .busByte(busByte), .busLock(busLock),
        .busWdata(busWdata), .busAck(busAck), .busRdata(busRdata));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (intOp === 1'b1) nInt++;
    task automatic wrap_up;
        $display("Compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int i, input logic [31:0] a, input logic w);
        chk({i_mem.logK[i][2], i_mem.logA[i]}, {w, a});
    endtask : cyc
    // one command, then a bounded wait for its done pulse
    task automatic run(input logic [2:0] kind);
        int n;
        @(posedge sys_clk) #1;
        while (cmdReady !== 1'b1) @(posedge sys_clk) #1;
        i_mem.logA.delete();
        i_mem.logD.delete();
        i_mem.logK.delete();
        nInt = 0;
        cmdKind = kind;
        cmdValid = 1'b1;
        @(posedge sys_clk) #1;
        cmdValid = 1'b0;
        n = 0;
        while (seqDone !== 1'b1 && n < 400) begin
            @(posedge sys_clk) #1;
            n++;
        end
        chk(n < 400, 1'b1);
    endtask : run
    task automatic t_reset;
        run(3'h0);
        chk(i_mem.logA.size(), 3);
        cyc(0, 32'h40, 1'b0);
        cyc(1, 32'h42, 1'b0);
        cyc(2, 32'h5a1a5a18, 1'b0);
        chk(nInt, 1);
    endtask : t_reset
    task automatic t_exc(input logic [2:0] kind, input int wake);
        wakeRecovery = wake[0];
        run(kind);
        wakeRecovery = 1'b0;
        chk(i_mem.logA.size(), 7 - wake);
        if (wake == 0) cyc(0, 32'h2002, 1'b0);
        cyc(1 - wake, 32'hffe, 1'b1);
        cyc(2 - wake, 32'hffc, 1'b1);
        cyc(3 - wake, 32'hffa, 1'b1);
        cyc(4 - wake, 32'h40, 1'b0);
        chk(i_mem.logK[4 - wake][1], 1'b1);
        cyc(5 - wake, 32'h42, 1'b0);
        cyc(6 - wake, 32'h5a1a5a18, 1'b0);
        chk(i_mem.logD[1 - wake], 16'h2000);
        chk(i_mem.logD[3 - wake], 16'h0007);
        chk(fetchAddr, 32'h5a1a5a18);
        chk(nInt, 2 + wake);
    endtask : t_exc
    task automatic t_ret_tset;
        run(3'h3);
        chk(i_mem.logA.size(), 1);
        cyc(0, 32'h4000, 1'b0);
        run(3'h4);
        cyc(0, 32'h3000, 1'b0);
        cyc(1, 32'h3000, 1'b1);
        chk({i_mem.logK[0], i_mem.logK[1]}, 6'h1f);
        chk(i_mem.logD[1], 16'h00da);
    endtask : t_ret_tset
    task automatic t_move(input logic [15:0] w, input int n);
        countRegWord = w;
        run(3'h5);
        chk(i_mem.logA.size(), 2 * n);
        for (int i = 0; i < n; i++) begin
            cyc(2 * i, 32'h5000 + i, 1'b0);
            cyc(2 * i + 1, 32'h6000 + i, 1'b1);
        end
        chk(srcAddr, 32'h5000 + n);
        chk(dstAddr, 32'h6000 + n);
    endtask : t_move
    task automatic t_multi(input int r, input int n);
        multiRestore = r[0];
        regCount = n[2:0];
        run(3'h6);
        chk(i_mem.logA.size(), 2 * n);
        for (int i = 0; i < n; i++) begin
            cyc(2 * i, r ? 32'h1000 + 4 * i : 32'hffc - 4 * i, !r);
            cyc(2 * i + 1, r ? 32'h1002 + 4 * i : 32'hffe - 4 * i, !r);
        end
        chk(stackOut, r ? 32'h1000 + 4 * n : 32'h1000 - 4 * n);
        chk(regIdx, n & 3);
        if (r) chk(restoreWord, 32'h4a5e4a5c);
        else chk(i_mem.logD[1], 16'h3344);
    endtask : t_multi
    initial begin
        {cmdValid, wakeRecovery, multiRestore, countIsWord, slowMode} = 5'h00;
        {cmdKind, regCount, countRegWord} = 22'h000000;
        {gpRegFive, gpRegSix, stackPtr, progCounter} = {32'h5000, 32'h6000, 32'h1000, 32'h2000};
        {vectorAddress, returnAddr, effAddr, saveWord} = {32'h40, 32'h4000, 32'h3000, 32'h11223344};
        extendedControlWord = 8'h07;
        sys_rst = 1'b1;
        repeat (8) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        t_reset();
        t_exc(3'h1, 0);
        t_exc(3'h2, 0);
        slowMode = 1'b1;
        t_exc(3'h1, 1);
        t_ret_tset();
        slowMode = 1'b0;
        t_move(16'h0103, 3);
        t_move(16'h0100, 0);
        countIsWord = 1'b1;
        t_move(16'h0002, 2);
        t_multi(0, 3);
        t_multi(1, 2);
        t_multi(0, 4);
        wrap_up();
    end
    initial begin
        #1000000;
        error_cnt++;
        wrap_up();
    end
endmodule : test_csq_sequencer
`default_nettype wire
